// >>> design/vsic_top.sv
// Video sync, display mode and blanking / line / mono-sense interrupt block with APB
`timescale 1ns/1ps

// Overview of operation
// - Mono sense pin, active low, readable
// - Any mono sense change interrupts when enabled
// - Register selects sync source and field rate
// - Sync select register read/write, resets zero
// - Software-driven aux sync select output pin
// - Separate horizontal and vertical blanking interrupts
// - Line timer decrements on each event
// - Active-high event; interrupt on count expiry
// - Display enable feeds the line timer
// - Depth selects one of three modes
module vsic_top (
  input wire logic clk_in,                         // 20 MHz system clock
  input wire logic reset_n_in,                     // Synchronous reset, low
  // APB slave
  input wire logic psel_in,                        // Select
  input wire logic penable_in,                     // Access phase
  input wire logic pwrite_in,                      // 1 = write
  input wire logic [31:0] paddr_in,                // Byte address
  input wire logic [31:0] pwdata_in,               // Write data
  output logic [31:0] prdata_out,                  // Read data
  output logic pready_out,                         // Transfer done
  output logic pslverr_out,                        // Unmapped address
  // Video timing and monitor pins
  input wire logic hblank_in,                      // Horizontal blank, high
  input wire logic vblank_in,                      // Vertical blank, high
  input wire logic disp_en_in,                     // Display enable, high
  input wire logic mono_sense_n_in,                // Mono monitor present, low
  output logic sync_ext_out,                       // 1 = external sync
  output logic field_60hz_out,                     // 1 = 60 Hz field
  output logic [1:0] display_depth_out,            // Display mode
  output logic aux_sync_sel_out,                   // Monitor sync source select
  // Interrupt requests to the CPU
  output logic hblank_irq_out,                     // One-cycle pulse
  output logic vblank_irq_out,                     // One-cycle pulse
  output logic line_tmr_irq_out,                   // One-cycle pulse
  output logic mono_irq_out                        // One-cycle pulse
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic pready;                                  // Answer strobe
    logic pslverr;                                 // Error with answer
    logic [31:0] prdata;                           // Read data

    logic [1:0] sync_sel;                          // Sync select register
    logic [1:0] depth;                             // Display depth register
    logic aux;                                     // Aux sync select output
    logic [vsic_pkg::IRQ_N-1:0] irq_en;            // Interrupt enables
    logic [vsic_pkg::TMR_W-1:0] tmr_start;         // Timer start value
    logic tmr_run;                                 // Timer run control
    logic tmr_load;                                // Timer load pulse

    logic [vsic_pkg::IRQ_N-1:0] irq;               // Interrupt pulses
  } vsic_top_t;

  // Current state and its next value
  vsic_top_t st_ff;
  vsic_top_t nxt_st;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  // Levels and one-cycle edges
  logic [vsic_pkg::PIN_N-1:0] pin_raw;
  logic [vsic_pkg::PIN_N-1:0] pin_lvl;
  logic [vsic_pkg::PIN_N-1:0] pin_rise;
  logic [vsic_pkg::PIN_N-1:0] pin_fall;

  // Bit order matches the status register layout
  assign pin_raw = {disp_en_in, vblank_in, hblank_in, mono_sense_n_in};

  // Two flops before any read
  vsic_sync_edge #(
    .W(vsic_pkg::PIN_N)
  ) u_sync (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .pin_in(pin_raw),
    .level_out(pin_lvl),
    .rise_out(pin_rise),
    .fall_out(pin_fall)
  );

  // ****************************************************************
  // Line timer
  // ****************************************************************
  vsic_tmr_if tif ();

  // Counts display lines down
  vsic_line_timer u_tmr (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .tif(tif)
  );

  // Timer counts the end of each displayed line
  assign tif.evt = pin_fall[vsic_pkg::ST_DE_BIT];

  // Register-side controls
  assign tif.load = st_ff.tmr_load;
  assign tif.start = st_ff.tmr_start;
  assign tif.run = st_ff.tmr_run;

  // ****************************************************************
  // APB decode
  // ****************************************************************
  logic acc;
  logic wr;
  logic [vsic_pkg::ADDR_W-1:0] ofs;
  logic mapped;
  logic [31:0] rd_mux;

  // Access completes on the second access cycle, when pready is high
  assign acc = psel_in & penable_in & ~st_ff.pready;

  // Write lands with the answer
  assign wr = psel_in & penable_in & st_ff.pready & pwrite_in & ~st_ff.pslverr;

  assign ofs = paddr_in[vsic_pkg::ADDR_W-1:0];

  // Read mux and address check; upper address bits must be zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    mapped = (paddr_in[31:vsic_pkg::ADDR_W] == 24'h00_0000);
    unique case (ofs)
      // Sync source, field rate
      vsic_pkg::SYNC_SEL_OFS: begin
        rd_mux[1:0] = st_ff.sync_sel;
      end

      // Display mode
      vsic_pkg::DEPTH_OFS: begin
        rd_mux[1:0] = st_ff.depth;
      end

      // Monitor sync pin
      vsic_pkg::AUX_OUT_OFS: begin
        rd_mux[0] = st_ff.aux;
      end

      // Source enables
      vsic_pkg::IRQ_EN_OFS: begin
        rd_mux[vsic_pkg::IRQ_N-1:0] = st_ff.irq_en;
      end

      // Start value
      vsic_pkg::TMR_START_OFS: begin
        rd_mux[vsic_pkg::TMR_W-1:0] = st_ff.tmr_start;
      end

      // Read only: live count
      vsic_pkg::TMR_COUNT_OFS: begin
        rd_mux[vsic_pkg::TMR_W-1:0] = tif.count;
      end

      // Run control
      vsic_pkg::TMR_CTRL_OFS: begin
        rd_mux[vsic_pkg::TMR_RUN_BIT] = st_ff.tmr_run;
      end

      // Read only: pin levels
      vsic_pkg::STATUS_OFS: begin
        rd_mux[vsic_pkg::PIN_N-1:0] = pin_lvl;
      end

      // Hole in the map
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    nxt_st = st_ff;

    nxt_st.pready = acc;
    nxt_st.tmr_load = 1'b0;

    // Data and error only with the answer
    if (acc) begin
      nxt_st.pslverr = ~mapped;
      nxt_st.prdata = (pwrite_in || !mapped) ? 32'h0000_0000 : rd_mux;
    end else begin
      nxt_st.pslverr = 1'b0;
      nxt_st.prdata = 32'h0000_0000;
    end

    // Register writes land on the completing edge only
    if (wr) begin
      unique case (ofs)
        // Sync source, field rate
        vsic_pkg::SYNC_SEL_OFS: begin
          nxt_st.sync_sel = pwdata_in[1:0];
        end

        // Display mode
        vsic_pkg::DEPTH_OFS: begin
          // Code 3 names no mode and is dropped; any time is accepted, so
          // picture tearing is the caller's concern
          if (pwdata_in[1:0] != 2'h3) begin
            nxt_st.depth = pwdata_in[1:0];
          end
        end

        // Monitor sync pin
        vsic_pkg::AUX_OUT_OFS: begin
          nxt_st.aux = pwdata_in[0];
        end

        // Source enables
        vsic_pkg::IRQ_EN_OFS: begin
          nxt_st.irq_en = pwdata_in[vsic_pkg::IRQ_N-1:0];
        end

        // Also reloads the count
        vsic_pkg::TMR_START_OFS: begin
          nxt_st.tmr_start = pwdata_in[vsic_pkg::TMR_W-1:0];
          nxt_st.tmr_load = 1'b1;
        end

        // Run control
        vsic_pkg::TMR_CTRL_OFS: begin
          nxt_st.tmr_run = pwdata_in[vsic_pkg::TMR_RUN_BIT];
        end

        default: begin
          nxt_st.tmr_load = 1'b0;                  // Read-only or unmapped
        end
      endcase
    end

    // Interrupt pulses, each gated by its enable

    // Once per line, as blank starts
    nxt_st.irq[vsic_pkg::IRQ_HBL_BIT] = st_ff.irq_en[vsic_pkg::IRQ_HBL_BIT]
      & pin_rise[vsic_pkg::ST_HBL_BIT];

    // Once per field
    nxt_st.irq[vsic_pkg::IRQ_VBL_BIT] = st_ff.irq_en[vsic_pkg::IRQ_VBL_BIT]
      & pin_rise[vsic_pkg::ST_VBL_BIT];

    // Timer expiry is already a pulse
    nxt_st.irq[vsic_pkg::IRQ_TMR_BIT] = st_ff.irq_en[vsic_pkg::IRQ_TMR_BIT]
      & tif.expire;

    // Both directions count; a plug or unplug must be seen either way
    nxt_st.irq[vsic_pkg::IRQ_MONO_BIT] = st_ff.irq_en[vsic_pkg::IRQ_MONO_BIT]
      & (pin_rise[vsic_pkg::ST_MONO_N_BIT] | pin_fall[vsic_pkg::ST_MONO_N_BIT]);
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  // Reset values from the package
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      st_ff <= '{
        pready: 1'b0,
        pslverr: 1'b0,
        prdata: 32'h0000_0000,
        sync_sel: vsic_pkg::SYNC_SEL_RST,
        depth: vsic_pkg::DEPTH_RST,
        aux: vsic_pkg::AUX_OUT_RST,
        irq_en: vsic_pkg::IRQ_EN_RST,
        tmr_start: vsic_pkg::TMR_START_RST,
        tmr_run: vsic_pkg::TMR_RUN_RST,
        tmr_load: 1'b0,
        irq: 4'h0
      };
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************************************
  // Outputs, all straight from flip-flops
  // ****************************************************************
  assign prdata_out = st_ff.prdata;
  assign pready_out = st_ff.pready;
  assign pslverr_out = st_ff.pslverr;

  // Monitor-side levels
  assign sync_ext_out = st_ff.sync_sel[vsic_pkg::SYNC_EXT_BIT];
  assign field_60hz_out = st_ff.sync_sel[vsic_pkg::SYNC_60HZ_BIT];
  assign display_depth_out = st_ff.depth;
  assign aux_sync_sel_out = st_ff.aux;

  // Interrupt pulses
  assign hblank_irq_out = st_ff.irq[vsic_pkg::IRQ_HBL_BIT];
  assign vblank_irq_out = st_ff.irq[vsic_pkg::IRQ_VBL_BIT];
  assign line_tmr_irq_out = st_ff.irq[vsic_pkg::IRQ_TMR_BIT];
  assign mono_irq_out = st_ff.irq[vsic_pkg::IRQ_MONO_BIT];

endmodule

// >>> design/vsic_pkg.sv
// Package: register map, field positions, reset values and widths of the video sync block
package vsic_pkg;

  // ****************************************************************
  // APB register byte offsets
  // ****************************************************************
  localparam logic [7:0] SYNC_SEL_OFS = 8'h00;     // Sync source and field rate
  localparam logic [7:0] DEPTH_OFS = 8'h04;        // Display depth mode
  localparam logic [7:0] AUX_OUT_OFS = 8'h08;      // Aux sync select output
  localparam logic [7:0] IRQ_EN_OFS = 8'h0C;       // Interrupt source enables
  localparam logic [7:0] TMR_START_OFS = 8'h10;    // Line timer start value
  localparam logic [7:0] TMR_COUNT_OFS = 8'h14;    // Line timer live count
  localparam logic [7:0] TMR_CTRL_OFS = 8'h18;     // Line timer control
  localparam logic [7:0] STATUS_OFS = 8'h1C;       // Pin levels

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int SYNC_EXT_BIT = 0;                 // 1 = external sync
  localparam int SYNC_60HZ_BIT = 1;                // 1 = 60 Hz field rate
  localparam int IRQ_HBL_BIT = 0;                  // Horizontal blank interrupt
  localparam int IRQ_VBL_BIT = 1;                  // Vertical blank interrupt
  localparam int IRQ_TMR_BIT = 2;                  // Line timer interrupt
  localparam int IRQ_MONO_BIT = 3;                 // Mono sense change interrupt
  localparam int TMR_RUN_BIT = 0;                  // Event count operation on
  localparam int ST_MONO_N_BIT = 0;                // Mono sense pin level
  localparam int ST_HBL_BIT = 1;                   // Horizontal blank level
  localparam int ST_VBL_BIT = 2;                   // Vertical blank level
  localparam int ST_DE_BIT = 3;                    // Display enable level

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int ADDR_W = 8;                       // APB address bits decoded
  localparam int TMR_W = 8;                        // Line timer width
  localparam int IRQ_N = 4;                        // Interrupt sources
  localparam int PIN_N = 4;                        // Synchronised input pins

  // ****************************************************************
  // Display depth encodings
  // ****************************************************************
  localparam logic [1:0] DEPTH_LO_4PL = 2'h0;      // 320 x 200, 4 planes
  localparam logic [1:0] DEPTH_MID_2PL = 2'h1;     // 640 x 200, 2 planes
  localparam logic [1:0] DEPTH_HI_1PL = 2'h2;      // 640 x 400, 1 plane

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [1:0] SYNC_SEL_RST = 2'h0;
  localparam logic [1:0] DEPTH_RST = 2'h0;
  localparam logic AUX_OUT_RST = 1'b0;
  localparam logic [IRQ_N-1:0] IRQ_EN_RST = 4'h0;
  localparam logic [TMR_W-1:0] TMR_START_RST = 8'h00;
  localparam logic TMR_RUN_RST = 1'b0;

endpackage

// >>> design/vsic_tmr_if.sv
// Interface: control link between the register block and the line timer
`timescale 1ns/1ps
interface vsic_tmr_if;
  logic load;                                      // One-cycle load of start value
  logic [vsic_pkg::TMR_W-1:0] start;               // Programmed start value
  logic run;                                       // Event count operation enabled
  logic evt;                                       // One-cycle event pulse
  logic expire;                                    // One-cycle expiry pulse
  logic [vsic_pkg::TMR_W-1:0] count;               // Live count

  modport ctrl (output load, output start, output run, output evt,
                input expire, input count);
  modport tmr (input load, input start, input run, input evt,
               output expire, output count);
endinterface

// >>> design/vsic_sync_edge.sv
// Two-flop pin synchroniser with rise and fall detection per bit
`timescale 1ns/1ps
module vsic_sync_edge #(
  parameter int W = 4
) (
  input wire logic clk_in,                         // System clock
  input wire logic reset_n_in,                     // Synchronous reset, low
  input wire logic [W-1:0] pin_in,                 // Asynchronous pins
  output logic [W-1:0] level_out,                  // Synchronised level
  output logic [W-1:0] rise_out,                   // One-cycle rise pulse
  output logic [W-1:0] fall_out                    // One-cycle fall pulse
);

  typedef struct packed {
    logic [W-1:0] meta;                            // First stage, read by stage two only
    logic [W-1:0] sync;                            // Second stage
    logic [W-1:0] prev;                            // Delayed copy for edges
  } vsic_se_t;

  vsic_se_t st_ff;
  vsic_se_t nxt_st;

  // Shift chain; edges look only at stage two and later
  always_comb begin
    nxt_st = st_ff;
    nxt_st.meta = pin_in;
    nxt_st.sync = st_ff.meta;
    nxt_st.prev = st_ff.sync;
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Per-bit edge detect
  for (genvar i = 0; i < W; i++) begin : g_edge
    assign level_out[i] = st_ff.sync[i];
    assign rise_out[i] = st_ff.sync[i] & ~st_ff.prev[i];
    assign fall_out[i] = ~st_ff.sync[i] & st_ff.prev[i];
  end

endmodule

// >>> design/vsic_line_timer.sv
// Line event down counter with automatic reload on expiry
`timescale 1ns/1ps
module vsic_line_timer (
  input wire logic clk_in,                         // System clock
  input wire logic reset_n_in,                     // Synchronous reset, low
  vsic_tmr_if.tmr tif                              // Control link
);

  typedef struct packed {
    logic [vsic_pkg::TMR_W-1:0] count;             // Live count
    logic expire;                                  // Expiry pulse
  } vsic_lt_t;

  vsic_lt_t st_ff;
  vsic_lt_t nxt_st;

  // Load wins over an event in the same cycle; start 0 behaves as 256 lines
  always_comb begin
    nxt_st = st_ff;
    nxt_st.expire = 1'b0;
    if (tif.load) begin
      nxt_st.count = tif.start;
    end else if (tif.run && tif.evt) begin
      if (st_ff.count == 8'h01) begin
        nxt_st.count = tif.start;
        nxt_st.expire = 1'b1;
      end else begin
        nxt_st.count = st_ff.count - 8'h01;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      st_ff <= '{count: vsic_pkg::TMR_START_RST, expire: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign tif.count = st_ff.count;
  assign tif.expire = st_ff.expire;

endmodule

// >>> tb/vsic_top_properties.sv
// Checker: concurrent properties on the ports of the video sync block
`timescale 1ns/1ps
module vsic_top_checker (
  input wire logic clk_in,                // System clock
  input wire logic reset_n_in,            // Synchronous reset, low
  input wire logic psel_in,               // APB select
  input wire logic penable_in,            // APB access phase
  input wire logic pwrite_in,             // APB direction
  input wire logic [31:0] paddr_in,       // APB address
  input wire logic [31:0] prdata_out,     // APB read data
  input wire logic pready_out,            // APB ready
  input wire logic pslverr_out,           // APB error
  input wire logic hblank_in,             // Horizontal blank
  input wire logic vblank_in,             // Vertical blank
  input wire logic mono_sense_n_in,       // Mono sense pin
  input wire logic sync_ext_out,          // External sync
  input wire logic field_60hz_out,        // Field rate
  input wire logic [1:0] display_depth_out, // Display mode
  input wire logic aux_sync_sel_out,      // Aux sync pin
  input wire logic hblank_irq_out,        // Horizontal irq
  input wire logic vblank_irq_out,        // Vertical irq
  input wire logic mono_irq_out           // Mono sense irq
);
  // ****************************************************************
  // Properties, all on the one system clock
  // ****************************************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  a_ready_after_access: assert property (psel_in && penable_in && !pready_out |=> pready_out)
    else $error("no ready one cycle into access");
  a_pready_single: assert property (pready_out |=> !pready_out)
    else $error("ready held over one cycle");
  a_rdata_idle_zero: assert property (!pready_out |-> prdata_out == 32'h0)
    else $error("read data outside answer cycle");
  a_err_unmapped: assert property (pready_out && paddr_in[31:8] != 24'h0 |-> pslverr_out)
    else $error("unmapped access not refused");
  // Pins only move at the write that targets them
  a_sync_by_write: assert property ($changed({field_60hz_out, sync_ext_out})
    |-> $past(pready_out && pwrite_in && paddr_in == 32'h0))
    else $error("sync select moved without a write");
  a_aux_by_write: assert property ($changed(aux_sync_sel_out)
    |-> $past(pready_out && pwrite_in && paddr_in == 32'h8))
    else $error("aux pin moved without a write");
  a_depth_legal: assert property (display_depth_out != 2'h3)
    else $error("illegal display depth");
  // Window of 2..6 cycles allows 2-flop sync plus register stage
  a_hbl_irq_cause: assert property (hblank_irq_out
    |-> $past(hblank_in, 2) && !$past(hblank_in, 6))
    else $error("hblank irq without blank start");
  a_vbl_irq_cause: assert property (vblank_irq_out
    |-> $past(vblank_in, 2) && !$past(vblank_in, 6))
    else $error("vblank irq without blank start");
  a_mono_irq_cause: assert property (mono_irq_out
    |-> $past(mono_sense_n_in, 2) != $past(mono_sense_n_in, 6))
    else $error("mono irq without sense change");
  a_irq_one_pulse: assert property (hblank_irq_out || vblank_irq_out
    |=> !(hblank_irq_out || vblank_irq_out))
    else $error("blank irq longer than one cycle");
endmodule

bind vsic_top vsic_top_checker u_chk (.clk_in, .reset_n_in, .psel_in, .penable_in, .pwrite_in,
  .paddr_in, .prdata_out, .pready_out, .pslverr_out, .hblank_in, .vblank_in, .mono_sense_n_in,
  .sync_ext_out, .field_60hz_out, .display_depth_out, .aux_sync_sel_out, .hblank_irq_out,
  .vblank_irq_out, .mono_irq_out);

// >>> tb/vsic_monitor_model.sv
// Partner model: monitor on the video connector, sense line and sync select
`timescale 1ns/1ps
module vsic_monitor_model (
  input wire logic clk_in,                // System clock
  input wire logic plugged_in,            // Mono monitor attached
  input wire logic aux_sync_sel_in,       // Sync source request
  output logic sense_n_out,               // Sense line, pulled up
  output logic ext_sync_seen_out          // Sync source in use
);
  // Pull-up keeps the line high with nothing attached
  initial sense_n_out = 1'b1;
  initial ext_sync_seen_out = 1'b0;
  // Attached monitor grounds the sense line, active low
  always @(posedge clk_in) begin
    sense_n_out <= !plugged_in;
  end
  // Monitor follows the remote sync select pin
  always @(posedge clk_in) begin
    ext_sync_seen_out <= aux_sync_sel_in;
  end
endmodule

// >>> tb/vsic_top_test.sv
// Testbench: APB register, pin and interrupt tests of the video sync block
`timescale 1ns/1ps
module vsic_top_test;
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic psel_in = 1'b0;
  logic penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic [31:0] paddr_in = 32'h0;
  logic [31:0] pwdata_in = 32'h0;
  logic hblank_in = 1'b0;
  logic vblank_in = 1'b0;
  logic disp_en_in = 1'b0;
  logic plugged = 1'b0;
  logic mono_sense_n_in, pready_out, pslverr_out, sync_ext_out, field_60hz_out;
  logic aux_sync_sel_out, ext_seen, er;
  logic hblank_irq_out, vblank_irq_out, line_tmr_irq_out, mono_irq_out;
  logic [1:0] display_depth_out;
  logic [31:0] prdata_out, rd;
  int error_cnt = 0;
  int checked = 0;
  int irq_n [4] = '{0, 0, 0, 0};
  int base [4];

  vsic_top dut (.clk_in, .reset_n_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
    .prdata_out, .pready_out, .pslverr_out, .hblank_in, .vblank_in, .disp_en_in,
    .mono_sense_n_in, .sync_ext_out, .field_60hz_out, .display_depth_out, .aux_sync_sel_out,
    .hblank_irq_out, .vblank_irq_out, .line_tmr_irq_out, .mono_irq_out);
  vsic_monitor_model monitor (.clk_in, .plugged_in(plugged), .aux_sync_sel_in(aux_sync_sel_out),
    .sense_n_out(mono_sense_n_in), .ext_sync_seen_out(ext_seen));

  // 20 MHz clock
  always #25 clk_in = ~clk_in;
  // Pulse counters, sampled on the rising edge after the one that drives the pulses
  always @(posedge clk_in) begin
    irq_n[0] += (hblank_irq_out === 1'b1);
    irq_n[1] += (vblank_irq_out === 1'b1);
    irq_n[2] += (line_tmr_irq_out === 1'b1);
    irq_n[3] += (mono_irq_out === 1'b1);
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask
  function automatic logic [31:0] ad(input logic [7:0] ofs);
    return {24'h0, ofs};
  endfunction
  // One APB transfer; waits for ready, the watchdog ends a hang
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_in);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready_out !== 1'b1);
    chk(n, 32'h2, "ready latency");
    rd = prdata_out;
    er = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp, "read data");
  endtask
  // Displayed line then horizontal blank; display enable falls once per line
  task automatic line();
    @(posedge clk_in);
    disp_en_in <= 1'b1;
    repeat (8) @(posedge clk_in);
    disp_en_in <= 1'b0;
    hblank_in <= 1'b1;
    repeat (8) @(posedge clk_in);
    hblank_in <= 1'b0;
    repeat (6) @(posedge clk_in);
  endtask
  task automatic vbl(input logic v);
    @(posedge clk_in);
    vblank_in <= v;
    repeat (10) @(posedge clk_in);
  endtask
  task automatic mono(input logic v);
    @(posedge clk_in);
    plugged <= v;
    repeat (12) @(posedge clk_in);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    repeat (8) @(posedge clk_in);
    reset_n_in <= 1'b1;
    // Reset values, then the sense pin level with nothing attached
    for (int i = 0; i < 7; i++) begin
      rdc(32'(i * 4), 32'h0);
    end
    rdc(ad(vsic_pkg::STATUS_OFS), 32'h1);
    apb(1'b0, 32'h20, 32'h0);
    chk(er, 1'b1, "unmapped read");
    apb(1'b1, 32'h104, 32'h3);
    chk(er, 1'b1, "unmapped write");
    $display("test reset and map done");
    // Every sync source and field rate combination
    for (int v = 0; v < 4; v++) begin
      apb(1'b1, ad(vsic_pkg::SYNC_SEL_OFS), 32'(v));
      rdc(ad(vsic_pkg::SYNC_SEL_OFS), 32'(v));
      chk({field_60hz_out, sync_ext_out}, 32'(v), "sync pins");
    end
    for (int v = 1; v >= 0; v--) begin
      apb(1'b1, ad(vsic_pkg::AUX_OUT_OFS), 32'(v));
      rdc(ad(vsic_pkg::AUX_OUT_OFS), 32'(v));
      chk({ext_seen, aux_sync_sel_out}, 32'(v * 3), "aux pin");
    end
    // Depth changes kept inside vertical blank; code 3 is refused
    vbl(1'b1);
    for (int v = 0; v < 4; v++) begin
      apb(1'b1, ad(vsic_pkg::DEPTH_OFS), 32'(v));
      rdc(ad(vsic_pkg::DEPTH_OFS), (v == 3) ? 32'h2 : 32'(v));
      chk(display_depth_out, (v == 3) ? 32'h2 : 32'(v), "depth pins");
    end
    vbl(1'b0);
    $display("test sync and depth done");
    // Each blanking source alone, the other masked
    for (int s = 0; s < 2; s++) begin
      apb(1'b1, ad(vsic_pkg::IRQ_EN_OFS), 32'(1 << s));
      base = irq_n;
      line();
      vbl(1'b1);
      vbl(1'b0);
      chk(irq_n[0] - base[0], 32'(s == 0), "hblank irqs");
      chk(irq_n[1] - base[1], 32'(s == 1), "vblank irqs");
    end
    $display("test blanking irqs done");
    // Sense change both ways when enabled, none when masked
    apb(1'b1, ad(vsic_pkg::IRQ_EN_OFS), 32'h8);
    base = irq_n;
    mono(1'b1);
    rdc(ad(vsic_pkg::STATUS_OFS), 32'h0);
    mono(1'b0);
    chk(irq_n[3] - base[3], 32'h2, "mono irqs");
    apb(1'b1, ad(vsic_pkg::IRQ_EN_OFS), 32'h0);
    base = irq_n;
    mono(1'b1);
    mono(1'b0);
    chk(irq_n[3] - base[3], 32'h0, "masked mono irqs");
    $display("test mono sense done");
    // Start 3: seven lines give expiries at 3 and 6, then count 2
    apb(1'b1, ad(vsic_pkg::TMR_CTRL_OFS), 32'h1);
    apb(1'b1, ad(vsic_pkg::IRQ_EN_OFS), 32'h4);
    apb(1'b1, ad(vsic_pkg::TMR_START_OFS), 32'h3);
    base = irq_n;
    line();
    rdc(ad(vsic_pkg::TMR_COUNT_OFS), 32'h2);
    repeat (6) line();
    rdc(ad(vsic_pkg::TMR_COUNT_OFS), 32'h2);
    chk(irq_n[2] - base[2], 32'h2, "timer irqs");
    $display("test line timer done");
    print_verdict();
  end

  // Watchdog well past the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk_in);
    error_cnt++;
    $display("[ERR] %0t watchdog expired", $time);
    print_verdict();
  end
endmodule
